// ===== verilog/pmc_meter_top.sv
// Panel meter top: pin sync, transfer window, latches, AXI4-Lite registers
`timescale 1ns/1ps
module pmc_meter_top (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       meter_reset_n,
    input  wire logic                       transfer_n,
    input  wire logic [pmc_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                 awprot,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    input  wire logic [pmc_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                 arprot,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    output logic                            irq,
    output logic                            integrate_out,
    output logic [3:0]                      bcd_out,
    output logic                            digit_sel_least,
    output logic                            digit_sel_third,
    output logic                            digit_sel_second,
    output logic                            digit_sel_most,
    output logic                            ten_thousands_out,
    output logic                            polarity_out
);
    logic [1:0]  rst_sync;
    logic [1:0]  xfer_sync;
    logic        rst_in_n;
    logic        xfer_low;
    logic        fell_high;
    logic        copy_en;
    logic [15:0] count_bcd;
    logic [1:0]  count_quad;
    logic        count_half;
    logic [1:0]  scan_idx;

    logic [15:0] latch_bcd;
    logic [1:0]  latch_quad;
    logic        latch_half;

    logic        int_prev;
    logic [1:0]  ctrl;

    logic [pmc_pkg::IRQ_W-1:0] irq_stat;
    logic [pmc_pkg::IRQ_W-1:0] irq_mask;
    logic [pmc_pkg::IRQ_W-1:0] irq_event;
    logic [pmc_pkg::IRQ_W-1:0] irq_clr;
    logic [pmc_pkg::IRQ_W-1:0] next_irq_stat;

    logic                      aw_got;
    logic                      w_got;
    logic [pmc_pkg::ADDR_W-1:0] aw_addr_q;
    logic [31:0]               w_data_q;
    logic [3:0]                w_strb_q;
    logic                      next_aw_got;
    logic                      next_w_got;
    logic                      next_bvalid;
    logic                      do_write;

    // Two-flop synchronisers for the external reset and transfer pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_sync  <= 2'h0;
            xfer_sync <= 2'h3;
        end else begin
            rst_sync  <= {rst_sync[0], meter_reset_n};
            xfer_sync <= {xfer_sync[0], transfer_n};
        end
    end

    // Software reset is already on this clock
    assign rst_in_n = rst_sync[1] & ~ctrl[pmc_pkg::CTRL_SOFT_RST];
    // Comparator drives the transfer pulse; a software force acts the same
    assign xfer_low = ~xfer_sync[1] | ctrl[pmc_pkg::CTRL_FORCE_XFER];

    pmc_count_chain u_chain (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .rst_in_n   (rst_in_n),
        .count_bcd  (count_bcd),
        .count_quad (count_quad),
        .count_half (count_half),
        .scan_idx   (scan_idx),
        .integrate  (integrate_out)
    );

    // Falling edge seen while transfer is released
    always_ff @(negedge aclk) begin
        if (!aresetn) begin
            fell_high <= 1'b0;
        end else begin
            fell_high <= ~xfer_low;
        end
    end

    // Level held low keeps latches following
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            copy_en <= 1'b0;
        end else if (xfer_low) begin
            copy_en <= 1'b1;
        end else if (fell_high) begin
            copy_en <= 1'b0;
        end
    end

    // Latches sample on rising edges, half a cycle clear of counter changes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_bcd  <= 16'h0000;
            latch_quad <= 2'h0;
            latch_half <= 1'b0;
        end else if (copy_en) begin
            latch_bcd  <= count_bcd;
            latch_quad <= count_quad;
            latch_half <= count_half;
        end
    end

    // Display reads only the latches
    pmc_digit_mux u_mux (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .latch_bcd         (latch_bcd),
        .latch_quad        (latch_quad),
        .latch_half        (latch_half),
        .scan_idx          (scan_idx),
        .bcd_out           (bcd_out),
        .digit_sel_least   (digit_sel_least),
        .digit_sel_third   (digit_sel_third),
        .digit_sel_second  (digit_sel_second),
        .digit_sel_most    (digit_sel_most),
        .ten_thousands_out (ten_thousands_out),
        .polarity_out      (polarity_out)
    );

    // Event detection for the interrupt status register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_prev <= 1'b1;
        end else begin
            int_prev <= integrate_out;
        end
    end

    always_comb begin
        irq_event = '0;
        irq_event[pmc_pkg::IRQ_XFER_DONE] = copy_en & ~xfer_low & fell_high;
        irq_event[pmc_pkg::IRQ_INT_END]   = int_prev & ~integrate_out;
        irq_event[pmc_pkg::IRQ_OVERRANGE] = copy_en & ~xfer_low & fell_high
                                            & ~count_half;
    end

    // AXI4-Lite write path: address and data taken in either order
    assign do_write = aw_got & w_got & ~bvalid;

    always_comb begin
        next_aw_got = aw_got;
        next_w_got  = w_got;
        next_bvalid = bvalid;
        if (awvalid && awready) begin
            next_aw_got = 1'b1;
        end
        if (wvalid && wready) begin
            next_w_got = 1'b1;
        end
        if (do_write) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
    end

    // Ready stays low until the response goes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            bvalid  <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
        end else begin
            aw_got  <= next_aw_got;
            w_got   <= next_w_got;
            bvalid  <= next_bvalid;
            awready <= ~next_aw_got & ~next_bvalid;
            wready  <= ~next_w_got & ~next_bvalid;
        end
    end

    // Each payload kept at its own handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= '0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
        end
    end

    // Unmapped offsets answer an error only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp <= pmc_pkg::RESP_OKAY;
        end else if (do_write) begin
            case (aw_addr_q)
                pmc_pkg::ADDR_CTRL,
                pmc_pkg::ADDR_COUNT,
                pmc_pkg::ADDR_LATCH,
                pmc_pkg::ADDR_IRQ_STAT,
                pmc_pkg::ADDR_IRQ_MASK: bresp <= pmc_pkg::RESP_OKAY;
                default:                bresp <= pmc_pkg::RESP_SLVERR;
            endcase
        end
    end

    // Control and mask live in byte lane 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl     <= pmc_pkg::CTRL_RST_VAL;
            irq_mask <= pmc_pkg::IRQ_MASK_RST;
        end else if (do_write && w_strb_q[0]) begin
            if (aw_addr_q == pmc_pkg::ADDR_CTRL) begin
                ctrl <= w_data_q[1:0];
            end
            if (aw_addr_q == pmc_pkg::ADDR_IRQ_MASK) begin
                irq_mask <= w_data_q[pmc_pkg::IRQ_W-1:0];
            end
        end
    end

    // Write one to clear; a new event in the same cycle wins
    always_comb begin
        irq_clr = '0;
        if (do_write && w_strb_q[0] && aw_addr_q == pmc_pkg::ADDR_IRQ_STAT) begin
            irq_clr = w_data_q[pmc_pkg::IRQ_W-1:0];
        end
        next_irq_stat = (irq_stat & ~irq_clr) | irq_event;
    end

    // Flopped so a clear never glitches irq
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= '0;
            irq      <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq      <= |(next_irq_stat & irq_mask);
        end
    end

    // AXI4-Lite read path: one read at a time, answer one cycle after taking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= pmc_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= pmc_pkg::RESP_OKAY;
            case (araddr)
                pmc_pkg::ADDR_CTRL:     rdata <= {30'h0000_0000, ctrl};
                pmc_pkg::ADDR_COUNT:    rdata <= {12'h000, integrate_out, count_half,
                                                  count_quad, count_bcd};
                pmc_pkg::ADDR_LATCH:    rdata <= {13'h0000, latch_half, latch_quad,
                                                  latch_bcd};
                pmc_pkg::ADDR_IRQ_STAT: rdata <= {29'h0000_0000, irq_stat};
                pmc_pkg::ADDR_IRQ_MASK: rdata <= {29'h0000_0000, irq_mask};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= pmc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid) begin
            if (rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end else begin
            arready <= 1'b1;
        end
    end
endmodule : pmc_meter_top

// ===== verilog/pmc_pkg.sv
// Shared constants for the panel meter count, latch and display block
// Behaviour
// - Four decades, mod-4, mod-2: 80,000 count cycle
// - Counters step on falling clock edge, ripple carry
// - Mod-2 toggles on rising previous stage output
// - Reset clears counters, sets integrate flop
// - Internal reset ends one falling edge later
// - Transfer low copies counters into latches
// - Copy stops rising edge after next fall
// - Integrate high until 18,000th clock pulse
// - Scan counter steps on second decade carry
// - Active-low strobe marks displayed decade latch
// - Overrange bit zero blanks outputs, flips sign
// - In range, sign one: nines complement
// - In range, sign zero: true BCD outputs
// - Transfer before 20,000 shows plus overrange
// - Counts 20,000 to 39,999 read +1.9999 down
// - 40,000 reads -0000; 60,000 minus overrange
package pmc_pkg;
    localparam int         NUM_DECADES     = 4;
    localparam logic [3:0] DEC_MAX         = 4'h9;
    localparam logic [1:0] QUAD_PRE_TOGGLE = 2'h1;
    // Last count before integrate falls: 17,999
    localparam logic [15:0] INT_END_BCD    = 16'h7999;
    localparam logic [1:0]  INT_END_QUAD   = 2'h1;
    localparam logic [3:0]  BCD_BLANK      = 4'hf;

    localparam int         ADDR_W          = 8;
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_COUNT      = 8'h04;
    localparam logic [7:0] ADDR_LATCH      = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT   = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;

    localparam int         CTRL_SOFT_RST   = 0;
    localparam int         CTRL_FORCE_XFER = 1;
    localparam logic [1:0] CTRL_RST_VAL    = 2'h0;

    localparam int         IRQ_W           = 3;
    localparam int         IRQ_XFER_DONE   = 0;
    localparam int         IRQ_INT_END     = 1;
    localparam int         IRQ_OVERRANGE   = 2;
    localparam logic [2:0] IRQ_MASK_RST    = 3'h0;

    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;
endpackage : pmc_pkg

// ===== verilog/pmc_count_chain.sv
// Falling-edge counter chain, scan counter and integrate flop
`timescale 1ns/1ps
module pmc_count_chain (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        rst_in_n,
    output logic [15:0]      count_bcd,
    output logic [1:0]       count_quad,
    output logic             count_half,
    output logic [1:0]       scan_idx,
    output logic             integrate
);
    logic       int_rst;
    logic       clear;
    logic [4:0] cin;

    // Held one extra falling edge so counting starts after an idle cycle
    always_ff @(negedge aclk) begin
        if (!aresetn) begin
            int_rst <= 1'b1;
        end else begin
            int_rst <= ~rst_in_n;
        end
    end

    assign clear  = int_rst | ~rst_in_n;
    assign cin[0] = 1'b1;

    genvar i;
    for (i = 0; i < pmc_pkg::NUM_DECADES; i++) begin : g_dec
        assign cin[i+1] = cin[i] & (count_bcd[4*i +: 4] == pmc_pkg::DEC_MAX);
        always_ff @(negedge aclk) begin
            if (!aresetn || clear) begin
                count_bcd[4*i +: 4] <= 4'h0;
            end else if (cin[i]) begin
                if (count_bcd[4*i +: 4] == pmc_pkg::DEC_MAX) begin
                    count_bcd[4*i +: 4] <= 4'h0;
                end else begin
                    count_bcd[4*i +: 4] <= count_bcd[4*i +: 4] + 4'h1;
                end
            end
        end
    end

    always_ff @(negedge aclk) begin
        if (!aresetn || clear) begin
            count_quad <= 2'h0;
            count_half <= 1'b0;
        end else if (cin[4]) begin
            count_quad <= count_quad + 2'h1;
            // Quad bit 1 rises only when leaving value 1
            if (count_quad == pmc_pkg::QUAD_PRE_TOGGLE) begin
                count_half <= ~count_half;
            end
        end
    end

    // Scan counter is not cleared by the meter reset; it only paces the display
    always_ff @(negedge aclk) begin
        if (!aresetn) begin
            scan_idx <= 2'h0;
        end else if (cin[2]) begin
            scan_idx <= scan_idx + 2'h1;
        end
    end

    always_ff @(negedge aclk) begin
        if (!aresetn || clear) begin
            integrate <= 1'b1;
        end else if (count_quad == pmc_pkg::INT_END_QUAD
                     && count_bcd == pmc_pkg::INT_END_BCD) begin
            integrate <= 1'b0;
        end
    end
endmodule : pmc_count_chain

// ===== verilog/pmc_digit_mux.sv
// Display multiplexer with overrange blanking and sign/complement coding
`timescale 1ns/1ps
module pmc_digit_mux (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [15:0] latch_bcd,
    input  wire logic [1:0]  latch_quad,
    input  wire logic        latch_half,
    input  wire logic [1:0]  scan_idx,
    output logic [3:0]       bcd_out,
    output logic             digit_sel_least,
    output logic             digit_sel_third,
    output logic             digit_sel_second,
    output logic             digit_sel_most,
    output logic             ten_thousands_out,
    output logic             polarity_out
);
    logic [3:0] digit;
    logic       in_range;
    logic       sign_bit;
    logic       tk_bit;

    assign in_range = latch_half;
    assign sign_bit = latch_quad[1];
    assign tk_bit   = latch_quad[0];

    always_comb begin
        case (scan_idx)
            2'h0:    digit = latch_bcd[3:0];
            2'h1:    digit = latch_bcd[7:4];
            2'h2:    digit = latch_bcd[11:8];
            default: digit = latch_bcd[15:12];
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            digit_sel_least  <= 1'b1;
            digit_sel_third  <= 1'b1;
            digit_sel_second <= 1'b1;
            digit_sel_most   <= 1'b1;
        end else begin
            digit_sel_least  <= ~(scan_idx == 2'h0);
            digit_sel_third  <= ~(scan_idx == 2'h1);
            digit_sel_second <= ~(scan_idx == 2'h2);
            digit_sel_most   <= ~(scan_idx == 2'h3);
        end
    end

    // Strobe and digit share one edge so the decoder never sees a mismatch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bcd_out           <= pmc_pkg::BCD_BLANK;
            ten_thousands_out <= 1'b1;
            polarity_out      <= 1'b1;
        end else if (!in_range) begin
            bcd_out           <= pmc_pkg::BCD_BLANK;
            ten_thousands_out <= 1'b1;
            polarity_out      <= ~sign_bit;
        end else if (sign_bit) begin
            bcd_out           <= pmc_pkg::DEC_MAX - digit;
            ten_thousands_out <= ~tk_bit;
            polarity_out      <= sign_bit;
        end else begin
            bcd_out           <= digit;
            ten_thousands_out <= tk_bit;
            polarity_out      <= sign_bit;
        end
    end
endmodule : pmc_digit_mux

// ===== verification/pmc_meter_checker.sv
// Port-level assertions for the panel meter top
`timescale 1ns/1ps
module pmc_meter_checker (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       meter_reset_n,
    input wire logic       integrate_out,
    input wire logic [3:0] bcd_out,
    input wire logic       digit_sel_least,
    input wire logic       digit_sel_third,
    input wire logic       digit_sel_second,
    input wire logic       digit_sel_most,
    input wire logic       ten_thousands_out
);
    logic [15:0] int_cnt;
    // Length of the integrate phase since the meter reset pin let go
    always_ff @(posedge aclk) begin
        if (!aresetn || !meter_reset_n) begin
            int_cnt <= 16'h0;
        end else if (integrate_out) begin
            int_cnt <= int_cnt + 16'h1;
        end
    end
    a_int_held_reset: assert property (
        @(posedge aclk) disable iff (!aresetn) (!meter_reset_n)[*4] |-> integrate_out)
        else $error("integrate low during meter reset");
    // Margin covers pin sync and the one idle count after reset
    a_int_fall_count: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $fell(integrate_out) |-> int_cnt >= 16'h464e && int_cnt <= 16'h4658)
        else $error("integrate phase length wrong");
    a_bcd_legal: assert property (
        @(posedge aclk) disable iff (!aresetn) bcd_out <= 4'h9 || bcd_out == 4'hf)
        else $error("digit code out of range");
    a_blank_ten_k: assert property (
        @(posedge aclk) disable iff (!aresetn) bcd_out == 4'hf |-> ten_thousands_out)
        else $error("blanked digit without blanked ten thousands");
    a_one_strobe: assert property (
        @(posedge aclk) disable iff (!aresetn) $countones({~digit_sel_least, ~digit_sel_third,
        ~digit_sel_second, ~digit_sel_most}) <= 1)
        else $error("more than one digit strobe low");
    a_least_dwell: assert property (
        @(posedge aclk) disable iff (!aresetn) $fell(digit_sel_least) |=> (!digit_sel_least)[*8])
        else $error("scan left the least digit too early");
    a_least_to_third: assert property (
        @(posedge aclk) disable iff (!aresetn) $rose(digit_sel_least) |-> !digit_sel_third)
        else $error("scan did not move to the third digit");
    a_most_to_least: assert property (
        @(posedge aclk) disable iff (!aresetn) $rose(digit_sel_most) |-> !digit_sel_least)
        else $error("scan did not wrap to the least digit");
endmodule : pmc_meter_checker

bind pmc_meter_top pmc_meter_checker i_chk (
    .aclk(aclk), .aresetn(aresetn), .meter_reset_n(meter_reset_n),
    .integrate_out(integrate_out), .bcd_out(bcd_out), .digit_sel_least(digit_sel_least),
    .digit_sel_third(digit_sel_third), .digit_sel_second(digit_sel_second),
    .digit_sel_most(digit_sel_most), .ten_thousands_out(ten_thousands_out)
);

// ===== verification/pmc_comparator_model.sv
// Model of the external integrator and comparator driving transfer
`timescale 1ns/1ps
module pmc_comparator_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        integrate_out,
    input  wire logic        arm,
    input  wire logic [16:0] delay,
    output logic             transfer_n
);
    logic [16:0] dis_cnt;
    logic [1:0]  pulse_cnt;
    // Discharge time runs from the end of the integrate phase
    always_ff @(posedge aclk) begin
        if (!aresetn || integrate_out) begin
            dis_cnt <= 17'h0;
        end else begin
            dis_cnt <= dis_cnt + 17'h1;
        end
    end
    // Zero crossing gives a three-clock low pulse, long enough for the pin sync
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            transfer_n <= 1'b1;
            pulse_cnt  <= 2'h0;
        end else if (arm && dis_cnt == delay) begin
            transfer_n <= 1'b0;
            pulse_cnt  <= 2'h2;
        end else if (pulse_cnt != 2'h0) begin
            pulse_cnt <= pulse_cnt - 2'h1;
        end else begin
            transfer_n <= 1'b1;
        end
    end
endmodule : pmc_comparator_model

// ===== verification/pmc_meter_top_bench.sv
// Self-checking bench for the panel meter top
`timescale 1ns/1ps
module pmc_meter_top_bench;
    logic        aclk, aresetn, meter_reset_n, transfer_n, arm;
    logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic        arready, rvalid, irq, integrate_out, least, third, second, most, tk, pol;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd, lat;
    logic [1:0]  bresp, rresp, resp;
    logic [3:0]  bcd_out;
    logic [16:0] delay;
    int          error_cnt = 0;
    int          checks = 0;
    int          dly[4];

    pmc_meter_top i_dut (
        .aclk(aclk), .aresetn(aresetn), .meter_reset_n(meter_reset_n), .transfer_n(transfer_n),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irq(irq), .integrate_out(integrate_out), .bcd_out(bcd_out),
        .digit_sel_least(least), .digit_sel_third(third), .digit_sel_second(second),
        .digit_sel_most(most), .ten_thousands_out(tk), .polarity_out(pol)
    );
    pmc_comparator_model i_cmp (
        .aclk(aclk), .aresetn(aresetn), .integrate_out(integrate_out), .arm(arm),
        .delay(delay), .transfer_n(transfer_n)
    );

    initial aclk = 1'b0;
    always #20 aclk = ~aclk;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_cyc

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // Latch word back to the count it was taken at
    function automatic int count_of(input logic [31:0] l);
        int c;
        c = l[17:16] * 10000 + l[15:12] * 1000 + l[11:8] * 100 + l[7:4] * 10 + l[3:0];
        if (l[18] != l[17]) c += 40000;
        return c;
    endfunction : count_of

    // Expected {ten thousands, polarity, digit} for one scan position
    function automatic logic [5:0] exp_disp(input logic [31:0] l, input int i);
        logic [3:0] d;
        d = l[i*4 +: 4];
        if (!l[18]) return {1'b1, ~l[17], 4'hf};
        if (l[17]) return {~l[16], 1'b1, 4'h9 - d};
        return {l[16], 1'b0, d};
    endfunction : exp_disp

    task automatic chk_disp(input logic [31:0] l);
        logic [3:0] sel;
        for (int i = 0; i < 4; i++) begin
            sel = 4'hf;
            sel[i] = 1'b0;
            while ({most, second, third, least} !== sel) @(posedge aclk);
            wait_cyc(3);
            chk({tk, pol, bcd_out}, exp_disp(l, i), "display digit");
        end
    endtask : chk_disp

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        aresetn = 1'b0;
        meter_reset_n = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, arm} = 6'h0;
        {awaddr, araddr, wdata, delay} = '0;
        void'($urandom(8));
        dly = '{300 + $urandom % 500, 2500 + $urandom % 1000, 22000 + $urandom % 1000, 42005};
        wait_cyc(3);
        aresetn <= 1'b1;
        wait_cyc(2);
        chk({tk, pol, bcd_out, integrate_out, irq}, 8'hfe, "outputs after reset");
        axi_rd(pmc_pkg::ADDR_CTRL);
        chk(rd, 32'h0, "control reset value");
        axi_rd(8'h14);
        chk({rd, resp}, {32'h0, pmc_pkg::RESP_SLVERR}, "unmapped read");
        lat = $urandom;
        axi_wr(pmc_pkg::ADDR_IRQ_MASK, lat);
        axi_rd(pmc_pkg::ADDR_IRQ_MASK);
        chk(rd, {29'h0, lat[2:0]}, "mask read back");
        axi_wr(8'h18, lat);
        chk(resp, pmc_pkg::RESP_SLVERR, "unmapped write");
        axi_wr(pmc_pkg::ADDR_IRQ_MASK, 32'h1);
        meter_reset_n <= 1'b0;
        wait_cyc(6);
        axi_rd(pmc_pkg::ADDR_COUNT);
        chk(rd, 32'h0008_0000, "counters held clear");
        meter_reset_n <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            delay <= 17'(dly[k]);
            arm <= 1'b1;
            while (transfer_n === 1'b1) @(posedge aclk);
            while (transfer_n !== 1'b1) @(posedge aclk);
            arm <= 1'b0;
            wait_cyc(8);
            chk(integrate_out, 1'b0, "integrate after reference");
            axi_rd(pmc_pkg::ADDR_LATCH);
            lat = rd;
            chk((count_of(lat) - 18000 - dly[k]) inside {[0:14]}, 1'b1, "latched count");
            if (k == 0) begin
                chk(irq, 1'b1, "irq on transfer");
                axi_wr(pmc_pkg::ADDR_IRQ_STAT, 32'h1);
                axi_rd(pmc_pkg::ADDR_IRQ_STAT);
                chk(rd[0], 1'b0, "event cleared");
                axi_wr(pmc_pkg::ADDR_IRQ_MASK, 32'h0);
            end else begin
                chk(irq, 1'b0, "irq masked");
            end
            wait_cyc(200);
            axi_rd(pmc_pkg::ADDR_LATCH);
            chk(rd, lat, "latch hold");
            chk_disp(lat);
        end
        meter_reset_n <= 1'b0;
        wait_cyc(8);
        axi_rd(pmc_pkg::ADDR_LATCH);
        chk(rd, lat, "latch kept over meter reset");
        meter_reset_n <= 1'b1;
        axi_wr(pmc_pkg::ADDR_CTRL, 32'h3);
        axi_rd(pmc_pkg::ADDR_COUNT);
        chk(rd, 32'h0008_0000, "soft reset");
        axi_rd(pmc_pkg::ADDR_LATCH);
        chk(rd, 32'h0, "forced transfer");
        finish_test();
    end

    // Longest path is a transfer near count 60,000; allow half as much again
    initial begin
        #3600000;
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        finish_test();
    end
endmodule : pmc_meter_top_bench
